//--- fcr_pkg.sv
// Purpose: Shared constants and types for the FIFO control block.
// Assumes: 8-bit register offsets, 32-bit data port.
// Notes: Own offsets sit beside the fixed ones.
package fcr_pkg;
    // =========================================
    // Register offsets
    localparam logic [7:0] A_FIRST = 8'h0B;
    localparam logic [7:0] A_MODE = 8'h0D;
    localparam logic [7:0] A_STEP = 8'h0E;
    localparam logic [7:0] A_SEL = 8'h0F;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_DATA = 8'h80;
    localparam logic [7:0] A_HOLD = 8'h84;
    localparam logic [7:0] A_MASK = 8'hF4;
    localparam logic [7:0] A_CON = 8'hFA;
    // =========================================
    // Field positions
    localparam int DIR_BIT = 0;
    localparam int REV_BIT = 7;
    localparam int ADV_BIT = 0;
    localparam int CLR_BIT = 1;
    localparam int LOST_BIT = 2;
    localparam int IFF_BIT = 0;
    localparam int RAW_BIT = 1;
    localparam int SP_LO = 2;
    localparam int SP_HI = 4;
    localparam int RT_LO = 5;
    localparam int RT_HI = 7;
    // =========================================
    // Reset values and fixed codes
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] FLAG_BYTE = 8'h7E;
    localparam logic [7:0] ONES_BYTE = 8'hFF;
    localparam logic [3:0] SP_BASE = 4'h5;
    localparam int PW = 12; // Pointer width
    localparam int FW = 5; // Frame counter width
    // Data flow modes
    typedef enum logic [1:0] {
        FLOW_SIMPLE = 2'h0,
        FLOW_PICK = 2'h1,
        FLOW_SEQ = 2'h3
    } fcr_flow_t;
    // Routing switches of one FIFO
    typedef struct packed {
        logic fifo_line; // FIFO feeds line
        logic fifo_pcm; // FIFO feeds PCM
        logic line_pcm; // Line forwarded to PCM
        logic from_pcm; // Receive FIFO fed by PCM
        logic pcm_line; // PCM drives line
    } fcr_route_t;
endpackage : fcr_pkg

//--- fcr_ctrl.sv
// Purpose: Host control of a bank of HDLC/transparent FIFOs.
// Assumes: Data side and host share clk.
// Notes: Registers are write-only apart from data and status.
// Notes on behaviour
// - First sequence entry: direction bit, number.
// - Flow mode codes 00, 01, 11.
// - Arrangement and size fields partition SRAM; here only output, split fixed by IW and DW.
// - Advance bit steps frame counters, self-clears.
// - Clear resets counters, pointers, mask.
// - Lost clear resets lost flag.
// - Offset 0x0F selects queue below 11.
// - Bit order swap reverses stored data.
// - In sequence mode 0x0F holds list index.
// - Hold writes store without pointer advance.
// - Hold byte repeats when transmit empties in raw mode.
// - Unused transmit bits come from fill mask.
// - Idle fill flags or all ones.
// - Raw mode selects transparent framing.
// - Transparent interrupt on low n wrap.
// - Spacing zero: no interrupt or disabled.
// - First interrupt after 2^n minus minimum.
// - Disabled FIFO carries no data.
// - Transmit route codes decoded.
// - Receive route codes decoded.
// - Raw and spacing zero disable FIFO.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module fcr_ctrl #(
    parameter int IW = 6, // FIFO index width
    parameter int DW = 4 // Log2 of bytes per FIFO
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic [1:0] wsize,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [2:0] sub_bit_count,
    input wire logic [2:0] sub_start,
    input wire logic rx_valid,
    input wire logic [IW-1:0] rx_idx,
    input wire logic [7:0] rx_byte,
    input wire logic tx_req,
    input wire logic [IW-1:0] tx_idx,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output fcr_pkg::fcr_route_t route,
    output logic fifo_irq,
    output logic [IW-1:0] irq_idx,
    output logic [1:0] flow_mode,
    output logic [1:0] arrangement,
    output logic [1:0] size_sel,
    output logic [5:0] first_entry,
    output logic [5:0] list_index
);
    import fcr_pkg::*;

    localparam int NF = 2 ** IW; // FIFO count
    localparam int DEPTH = 2 ** DW; // Bytes per FIFO
    localparam int AW = IW + DW; // Memory address width

    // =========================================
    // Elaboration check
    if (IW < 1 || IW > 6 || DW < 1 || DW > PW - 1) begin : g_chk
        $error("fcr_ctrl: IW or DW out of range");
    end

    // =========================================
    // Helper functions
    // Reverse bits of a byte
    function automatic logic [7:0] rev8(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction : rev8

    // FIFO enabled unless raw and spacing both zero
    function automatic logic en_f(input logic [7:0] c);
        return c[RAW_BIT] | (c[SP_HI:SP_LO] != 3'h0);
    endfunction : en_f

    // Transparent wrap of low n pointer bits
    function automatic logic hit_f(input logic [7:0] c,
                                   input logic [PW-1:0] nxt);
        logic [PW-1:0] m;
        m = PW'((13'h0001 << (SP_BASE + 4'(c[SP_HI:SP_LO]))) - 13'h1);
        // Zero spacing yields no interrupt; min pointer is zero
        return c[RAW_BIT] && (c[SP_HI:SP_LO] != 3'h0)
            && ((nxt & m) == '0);
    endfunction : hit_f

    // Memory address of one pointer slot
    function automatic logic [AW-1:0] ma_f(input logic [IW-1:0] f,
                                           input logic [PW-1:0] p);
        return {f, p[DW-1:0]};
    endfunction : ma_f

    // =========================================
    // State
    logic [7:0] mem [NF*DEPTH]; // Shared byte store
    logic [7:0] mask_q [NF]; // Unused bit fill
    logic [7:0] con_q [NF]; // Framing and routing
    logic [PW-1:0] wptr_q [NF]; // Write pointers
    logic [PW-1:0] rptr_q [NF]; // Read pointers
    logic [FW-1:0] fin_q [NF]; // Frames in
    logic [FW-1:0] fout_q [NF]; // Frames out
    logic [NF-1:0] lost_q; // Overflow flags
    logic [IW-1:0] sel_q; // Queue selection
    logic swap_q; // Bit order swap

    // =========================================
    // Decode of host and data strobes
    logic [IW-1:0] s; // Selected FIFO
    logic s_tx; // Selected is transmit
    logic w_first, w_mode, w_step, w_sel, w_data, w_hold;
    logic w_mask, w_con, r_data;
    logic do_adv, do_clr, do_lclr;
    logic rx_ok, rx_full, tx_ok, tx_empty;
    logic [PW-1:0] hw_nxt, hr_nxt, rw_nxt, tr_nxt;

    always_comb begin
        s = sel_q;
        s_tx = ~s[DIR_BIT];
        w_first = wr && addr == A_FIRST;
        w_mode = wr && addr == A_MODE;
        w_step = wr && addr == A_STEP;
        w_sel = wr && addr == A_SEL;
        w_data = wr && addr == A_DATA && s_tx;
        w_hold = wr && addr == A_HOLD && s_tx;
        w_mask = wr && addr == A_MASK;
        w_con = wr && addr == A_CON;
        r_data = rd && addr == A_DATA && !s_tx;
        do_adv = w_step && wdata[ADV_BIT];
        do_clr = w_step && wdata[CLR_BIT];
        do_lclr = w_step && wdata[LOST_BIT];
        hw_nxt = wptr_q[s] + PW'(1);
        hr_nxt = rptr_q[s] + PW'(1);
        rw_nxt = wptr_q[rx_idx] + PW'(1);
        tr_nxt = rptr_q[tx_idx] + PW'(1);
        rx_full = (wptr_q[rx_idx] - rptr_q[rx_idx]) == PW'(DEPTH);
        // Disabled FIFO drops line data
        rx_ok = rx_valid && rx_idx[DIR_BIT] && en_f(con_q[rx_idx]);
        tx_ok = tx_req && !tx_idx[DIR_BIT] && en_f(con_q[tx_idx]);
        tx_empty = wptr_q[tx_idx] == rptr_q[tx_idx];
    end

    // =========================================
    // Global mode registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flow_mode <= FLOW_SIMPLE;
            arrangement <= 2'h0;
            size_sel <= 2'h0;
            first_entry <= 6'h00;
        end else if (ce) begin
            if (w_mode) begin
                flow_mode <= wdata[3:2];
                arrangement <= wdata[1:0];
                size_sel <= wdata[5:4];
            end
            if (w_first) begin
                first_entry <= wdata[5:0];
            end
        end
    end

    // =========================================
    // Multi-register at the select offset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sel_q <= '0;
            swap_q <= 1'b0;
            list_index <= 6'h00;
        end else if (ce && w_sel) begin
            if (flow_mode == FLOW_SEQ) begin
                list_index <= wdata[5:0];
            end else begin
                // Bits from IW up are ignored, except REV_BIT for the swap
                sel_q <= wdata[IW-1:0];
                swap_q <= wdata[REV_BIT];
            end
        end
    end

    // =========================================
    // Per-FIFO configuration
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NF; i++) begin
                mask_q[i] <= MASK_RST;
                con_q[i] <= REG_RST;
            end
        end else if (ce) begin
            if (do_clr) begin
                mask_q[s] <= MASK_RST;
            end else if (w_mask) begin
                mask_q[s] <= wdata[7:0];
            end
            if (w_con) begin
                con_q[s] <= wdata[7:0];
            end
        end
    end

    // =========================================
    // Write pointers: host fills tx, line fills rx
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NF; i++) begin
                wptr_q[i] <= '0;
            end
        end else if (ce) begin
            if (rx_ok && !rx_full) begin
                wptr_q[rx_idx] <= rw_nxt;
            end
            if (do_clr) begin
                wptr_q[s] <= '0;
            end else if (w_data) begin
                wptr_q[s] <= hw_nxt;
            end
        end
    end

    // =========================================
    // Read pointers: line drains tx, host drains rx
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NF; i++) begin
                rptr_q[i] <= '0;
            end
        end else if (ce) begin
            if (tx_ok && !tx_empty) begin
                rptr_q[tx_idx] <= tr_nxt;
            end
            if (do_clr) begin
                rptr_q[s] <= '0;
            end else if (r_data) begin
                rptr_q[s] <= hr_nxt;
            end
        end
    end

    // =========================================
    // Frame counters
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NF; i++) begin
                fin_q[i] <= '0;
                fout_q[i] <= '0;
            end
        end else if (ce) begin
            if (do_clr) begin
                fin_q[s] <= '0;
                fout_q[s] <= '0;
            end else if (do_adv && s_tx) begin
                fin_q[s] <= fin_q[s] + FW'(1);
            end else if (do_adv) begin
                fout_q[s] <= fout_q[s] + FW'(1);
            end
        end
    end

    // =========================================
    // Lost flags; a new overflow beats the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lost_q <= '0;
        end else if (ce) begin
            if (do_lclr) begin
                lost_q[s] <= 1'b0;
            end
            if (rx_ok && rx_full) begin
                lost_q[rx_idx] <= 1'b1;
            end
        end
    end

    // =========================================
    // Byte store; hold writes leave the pointer
    always_ff @(posedge clk) begin
        if (ce) begin
            if (rx_ok && !rx_full) begin
                mem[ma_f(rx_idx, wptr_q[rx_idx])] <= rx_byte;
            end
            if (w_data) begin
                mem[ma_f(s, wptr_q[s])] <=
                    swap_q ? rev8(wdata[7:0]) : wdata[7:0];
            end else if (w_hold) begin
                // Size 0 byte, 1 word, 2 dword
                for (int k = 0; k < 4; k++) begin
                    if (k < (1 << wsize)) begin
                        mem[ma_f(s, wptr_q[s] + PW'(k))] <= swap_q
                            ? rev8(wdata[8*k+:8])
                            : wdata[8*k+:8];
                    end
                end
            end
        end
    end

    // =========================================
    // Transmit byte toward line or PCM
    logic [7:0] raw_b, fld, out_b;

    always_comb begin
        if (!tx_empty) begin
            raw_b = mem[ma_f(tx_idx, rptr_q[tx_idx])];
        end else if (con_q[tx_idx][RAW_BIT]) begin
            // Hold byte at the write pointer repeats until refilled
            raw_b = mem[ma_f(tx_idx, wptr_q[tx_idx])];
        end else begin
            raw_b = con_q[tx_idx][IFF_BIT] ? ONES_BYTE : FLAG_BYTE;
        end
        fld = 8'((9'h001 << sub_bit_count) - 9'h001) << sub_start;
        if (sub_bit_count == 3'h0) begin
            out_b = raw_b;
        end else begin
            out_b = (raw_b & fld) | (mask_q[tx_idx] & ~fld);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_valid <= 1'b0;
            tx_byte <= 8'h00;
        end else if (ce) begin
            tx_valid <= tx_ok;
            tx_byte <= tx_ok ? out_b : 8'h00;
        end
    end

    // =========================================
    // Route switches of the FIFO being served
    fcr_route_t rt_d;
    logic [2:0] rc;
    logic [IW-1:0] rf;

    always_comb begin
        rf = tx_req ? tx_idx : rx_idx;
        rc = con_q[rf][RT_HI:RT_LO];
        rt_d = '0;
        if (!rf[DIR_BIT]) begin
            rt_d.fifo_line = rc[2:1] != 2'h1 && rc[2:1] != 2'h3;
            rt_d.fifo_pcm = !rc[2];
            rt_d.line_pcm = rc[2];
        end else begin
            rt_d.from_pcm = rc[0];
            rt_d.pcm_line = rc[1];
        end
        // No switching through a disabled FIFO
        if (!en_f(con_q[rf])) begin
            rt_d = '0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            route <= '0;
        end else if (ce && (tx_req || rx_valid)) begin
            route <= rt_d;
        end
    end

    // =========================================
    // Interrupt pulse; line-side moves raise none
    logic ev;

    always_comb begin
        ev = 1'b0;
        if (w_data && hit_f(con_q[s], hw_nxt)) begin
            ev = 1'b1;
        end else if (r_data && hit_f(con_q[s], hr_nxt)) begin
            ev = 1'b1;
        end else if (do_adv && !con_q[s][RAW_BIT]
                     && con_q[s][SP_HI:SP_LO] != 3'h0) begin
            ev = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fifo_irq <= 1'b0;
            irq_idx <= '0;
        end else if (ce) begin
            fifo_irq <= ev;
            irq_idx <= s;
        end
    end

    // =========================================
    // Read port: data and status, one cycle later
    logic [7:0] rb;

    always_comb begin
        rb = mem[ma_f(s, rptr_q[s])];
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (ce) begin
            rdata <= '0;
            if (r_data) begin
                rdata <= {24'h0, swap_q ? rev8(rb) : rb};
            end else if (rd && addr == A_STAT) begin
                rdata <= {13'h0, wptr_q[s] == rptr_q[s],
                          en_f(con_q[s]), lost_q[s],
                          3'h0, fout_q[s], 3'h0, fin_q[s]};
            end
        end
    end
endmodule : fcr_ctrl

//--- fcr_ctrl_chk.sv
// Purpose: Port-level checks of the FIFO control block.
// Assumes: One clock domain, nrst asynchronous and active low.
// Notes: Bind statement at the foot of this file.
`timescale 1ns/1ps
module fcr_ctrl_chk
    import fcr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic rx_valid,
    input wire logic tx_req,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic fifo_irq,
    input wire logic [1:0] flow_mode,
    input wire logic [1:0] arrangement,
    input wire logic [1:0] size_sel,
    input wire logic [5:0] first_entry,
    input wire logic [5:0] list_index
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Write taken; ce low freezes all
    logic wr_go;
    assign wr_go = wr && ce;
    // =========================================
    // Configuration writes
    property p_flow_code;
        wr_go && addr == A_MODE |=> flow_mode == $past(wdata[3:2]);
    endproperty
    a_flow_code: assert property (p_flow_code)
        else $error("flow mode not taken");
    property p_arrange;
        wr_go && addr == A_MODE |=>
            arrangement == $past(wdata[1:0]) && size_sel == $past(wdata[5:4]);
    endproperty
    a_arrange: assert property (p_arrange)
        else $error("arrangement or size not taken");
    property p_first;
        wr_go && addr == A_FIRST |=> first_entry == $past(wdata[5:0]);
    endproperty
    a_first: assert property (p_first)
        else $error("first entry not taken");
    // No drift without a write
    property p_first_hold;
        !(wr_go && addr == A_FIRST) |=> $stable(first_entry);
    endproperty
    a_first_hold: assert property (p_first_hold)
        else $error("first entry changed without write");
    property p_index;
        wr_go && addr == A_SEL && flow_mode == 2'h3 |=>
            list_index == $past(wdata[5:0]);
    endproperty
    a_index: assert property (p_index)
        else $error("list index not taken");
    property p_index_keep;
        wr_go && addr == A_SEL && flow_mode != 2'h3 |=> $stable(list_index);
    endproperty
    a_index_keep: assert property (p_index_keep)
        else $error("list index changed by queue select");
    // =========================================
    // Data side
    property p_tx_cause;
        tx_valid && $past(ce) |-> $past(tx_req);
    endproperty
    a_tx_cause: assert property (p_tx_cause)
        else $error("transmit byte without request");
    property p_tx_quiet;
        !tx_valid |-> tx_byte == 8'h00;
    endproperty
    a_tx_quiet: assert property (p_tx_quiet)
        else $error("idle transmit byte not zero");
    // An interrupt needs an access
    property p_irq_cause;
        fifo_irq && $past(ce) |-> $past(wr || rd || rx_valid || tx_req);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("interrupt without access");
    // =========================================
    // Main scenarios
    c_irq: cover property (fifo_irq);
    c_seq_index: cover property (wr_go && addr == A_SEL && flow_mode == 2'h3);
    c_flag_fill: cover property (tx_valid && tx_byte == FLAG_BYTE);
endmodule : fcr_ctrl_chk

bind fcr_ctrl fcr_ctrl_chk i_fcr_ctrl_chk (.clk(clk), .nrst(nrst), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rx_valid(rx_valid),
    .tx_req(tx_req), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .fifo_irq(fifo_irq), .flow_mode(flow_mode), .arrangement(arrangement),
    .size_sel(size_sel), .first_entry(first_entry), .list_index(list_index));

//--- fcr_line_model.sv
// Purpose: Behavioural line and PCM side of the FIFO control block.
// Assumes: Requests change just after a rising edge.
// Notes: Idle lines show the inverse of the last value.
`timescale 1ns/1ps
module fcr_line_model #(
    parameter int IW = 6 // FIFO index width
) (
    input wire logic clk,
    output logic tx_req,
    output logic [IW-1:0] tx_idx,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    output logic rx_valid,
    output logic [IW-1:0] rx_idx,
    output logic [7:0] rx_byte
);
    // =========================================
    // Quiet lines at time zero
    initial begin
        tx_req = 1'b0;
        tx_idx = '0;
        rx_valid = 1'b0;
        rx_idx = '0;
        rx_byte = 8'h00;
    end
    // One-cycle byte request, answer taken the cycle after
    task automatic pull(input logic [IW-1:0] idx, output logic v,
                        output logic [7:0] b);
        @(posedge clk);
        tx_req <= 1'b1;
        tx_idx <= idx;
        @(posedge clk);
        tx_req <= 1'b0;
        tx_idx <= ~idx;
        @(negedge clk);
        v = tx_valid;
        b = tx_byte;
    endtask : pull
    // One-cycle delivery, then the inverse
    task automatic push(input logic [IW-1:0] idx, input logic [7:0] b);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_idx <= idx;
        rx_byte <= b;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_idx <= ~idx;
        rx_byte <= ~b;
        @(negedge clk);
    endtask : push
endmodule : fcr_line_model

//--- fcr_ctrl_test.sv
// Purpose: Self-checking bench of the FIFO control block.
// Assumes: 50 MHz clock, design built with 16-byte FIFOs.
// Notes: Route table first, then hand-written cases.
`timescale 1ns/1ps
module fcr_ctrl_test;
    import fcr_pkg::*;
    localparam int IW = 6;
    // Route code and expected switches per direction
    typedef struct packed {
        logic [2:0] code;
        logic [4:0] tx_e;
        logic [4:0] rx_e;
    } fcr_row_t;
    fcr_row_t rows [8] = '{'{3'h0, 5'h18, 5'h00}, '{3'h1, 5'h18, 5'h02},
        '{3'h2, 5'h08, 5'h01}, '{3'h3, 5'h08, 5'h03}, '{3'h4, 5'h14, 5'h00},
        '{3'h5, 5'h14, 5'h02}, '{3'h6, 5'h04, 5'h01}, '{3'h7, 5'h04, 5'h03}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [1:0] wsize = 2'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [2:0] sub_bit_count = 3'h0;
    logic [2:0] sub_start = 3'h0;
    logic tx_req, rx_valid, tx_valid, fifo_irq, got_v;
    logic [IW-1:0] tx_idx, rx_idx, irq_idx, irq_last;
    logic [7:0] rx_byte, tx_byte, got_b;
    logic [31:0] rdata;
    fcr_route_t route;
    logic [1:0] flow_mode, arrangement, size_sel;
    logic [5:0] first_entry, list_index;
    int error_cnt = 0;
    int check_count = 0;
    int irq_cnt = 0;
    int base;
    always #10 clk = ~clk;
    fcr_ctrl #(.IW(IW), .DW(4)) i_fcr_ctrl (.clk(clk), .nrst(nrst), .ce(ce),
        .addr(addr), .wdata(wdata), .wsize(wsize), .wr(wr), .rd(rd),
        .rdata(rdata), .sub_bit_count(sub_bit_count), .sub_start(sub_start),
        .rx_valid(rx_valid), .rx_idx(rx_idx), .rx_byte(rx_byte),
        .tx_req(tx_req), .tx_idx(tx_idx), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .route(route), .fifo_irq(fifo_irq),
        .irq_idx(irq_idx), .flow_mode(flow_mode), .arrangement(arrangement),
        .size_sel(size_sel), .first_entry(first_entry),
        .list_index(list_index));
    fcr_line_model #(.IW(IW)) i_fcr_line_model (.clk(clk), .tx_req(tx_req),
        .tx_idx(tx_idx), .tx_valid(tx_valid), .tx_byte(tx_byte),
        .rx_valid(rx_valid), .rx_idx(rx_idx), .rx_byte(rx_byte));
    // Count interrupt pulses
    always @(posedge clk) begin
        if (fifo_irq === 1'b1) begin
            irq_cnt <= irq_cnt + 1;
            irq_last <= irq_idx;
        end
    end
    // =========================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : chk
    // Callers keep reserved bits zero
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] sz = 2'h0);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wsize <= sz;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic [31:0] msk, input string what);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rdata & msk, exp, what);
    endtask : rd_chk
    task automatic pull(input logic [IW-1:0] idx, input logic ev,
                        input logic [7:0] eb, input string what);
        i_fcr_line_model.pull(idx, got_v, got_b);
        chk({23'h0, got_v, got_b}, {23'h0, ev, eb}, what);
    endtask : pull
    task automatic summarize;
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("[ERR] %0t timeout", $time);
        summarize();
    end
    // =========================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk({14'h0, flow_mode, arrangement, size_sel, first_entry,
             list_index}, 32'h0, "reset levels");
        foreach (rows[i]) begin
            wr_reg(A_SEL, 32'h02);
            wr_reg(A_CON, {24'h0, rows[i].code, 3'h1, 1'b0, rows[i].code[0]});
            pull(6'h02, 1'b1, rows[i].code[0] ? ONES_BYTE : FLAG_BYTE, "fill");
            chk({27'h0, route}, {27'h0, rows[i].tx_e}, "tx route");
            wr_reg(A_SEL, 32'h03);
            wr_reg(A_CON, {24'h0, rows[i].code, 3'h1, 2'h0});
            i_fcr_line_model.push(6'h03, 8'h5A);
            chk({27'h0, route}, {27'h0, rows[i].rx_e}, "rx route");
        end
        wr_reg(A_MODE, 32'h37);
        chk({26'h0, size_sel, flow_mode, arrangement}, 32'h37, "mode");
        rd_chk(A_MODE, 32'h0, 32'hFFFFFFFF, "write-only read");
        wr_reg(A_SEL, 32'h15);
        chk({26'h0, list_index}, 32'h0, "index kept");
        wr_reg(A_MODE, 32'h0C);
        wr_reg(A_SEL, 32'h3F);
        chk({26'h0, list_index}, 32'h3F, "index taken");
        wr_reg(A_FIRST, 32'h2B);
        chk({26'h0, first_entry}, 32'h2B, "first entry");
        @(posedge clk);
        ce <= 1'b0;
        wr_reg(A_FIRST, 32'h01);
        chk({26'h0, first_entry}, 32'h2B, "frozen");
        @(posedge clk);
        ce <= 1'b1;
        wr_reg(A_MODE, 32'h00);
        // Both enables zero: no output
        wr_reg(A_SEL, 32'h04);
        wr_reg(A_CON, 32'h00);
        pull(6'h04, 1'b0, 8'h00, "disabled fifo");
        wr_reg(A_SEL, 32'h06);
        wr_reg(A_CON, 32'h02);
        wr_reg(A_HOLD, 32'hA5);
        pull(6'h06, 1'b1, 8'hA5, "hold repeat");
        pull(6'h06, 1'b1, 8'hA5, "hold repeat");
        wr_reg(A_HOLD, 32'h11223344, 2'h2);
        pull(6'h06, 1'b1, 8'h44, "hold dword");
        @(posedge clk);
        sub_bit_count <= 3'h2;
        sub_start <= 3'h1;
        pull(6'h06, 1'b1, 8'hFD, "reset fill mask");
        wr_reg(A_MASK, 32'h00);
        pull(6'h06, 1'b1, 8'h04, "zero fill mask");
        @(posedge clk);
        sub_bit_count <= 3'h0;
        sub_start <= 3'h0;
        wr_reg(A_SEL, 32'h88);
        wr_reg(A_CON, 32'h02);
        wr_reg(A_DATA, 32'h01);
        pull(6'h08, 1'b1, 8'h80, "swapped byte");
        wr_reg(A_SEL, 32'h02);
        wr_reg(A_STEP, 32'h01);
        rd_chk(A_STAT, 32'h20001, 32'h31F1F, "frame step");
        wr_reg(A_STEP, 32'h02);
        rd_chk(A_STAT, 32'h20000, 32'h31F1F, "fifo clear");
        // Overrun a 16-byte receive FIFO by one byte
        wr_reg(A_SEL, 32'h05);
        wr_reg(A_CON, 32'h02);
        for (int k = 0; k < 17; k++)
            i_fcr_line_model.push(6'h05, k[7:0]);
        rd_chk(A_STAT, 32'h30000, 32'h30000, "lost set");
        wr_reg(A_STEP, 32'h04);
        rd_chk(A_STAT, 32'h20000, 32'h30000, "lost clear");
        // Read pointer wraps low 6 bits on read 64
        wr_reg(A_SEL, 32'h07);
        wr_reg(A_CON, 32'h06);
        base = irq_cnt;
        for (int k = 0; k < 64; k++) begin
            i_fcr_line_model.push(6'h07, k[7:0]);
            if (k == 63)
                chk(32'(irq_cnt - base) + fifo_irq, 32'h0, "early irq");
            rd_chk(A_DATA, {24'h0, k[7:0]}, 32'hFF, "rx data");
        end
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk(32'(irq_cnt - base), 32'h1, "irq count");
        chk({26'h0, irq_last}, 32'h07, "irq source");
        summarize();
    end
endmodule : fcr_ctrl_test
